// File: verification/tb_uart_modem_pin_and_mfout_control.sv
`timescale 1ns/1ps
`include "umpc_defs.svh"
module tb_uart_modem_pin_and_mfout_control;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        aclk = 1'b0, aresetn, dev_reset, tx_data, tx_busy, rx_bit;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, rx_data_avail, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, request_to_send_n;
  logic        terminal_ready_n, multi_function_out_n, serial_tx, rx_sample;
  logic        tx_allowed, irq, clear_to_send_n, set_ready_n, serial_rx;
  logic        carrier_detect_n, ring_indicator_n, b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, m;
  logic [3:0]  s_axi_wstrb, want;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
  int          seed = 32'he744c68d;
  umpc_top uut (.*);
  umpc_modem_model u_modem (.*);
  // 25 MHz clock; timeout cuts a hung handshake short
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task stop_test;
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Address and data offered together, each dropped when taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {resp, rdat} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  // Reserved select code behaves as the general output
  function automatic logic mf_exp(logic [1:0] sel, logic [31:0] c, logic r);
    return (sel == 2'h2) ? !r : !c[3];
  endfunction
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {dev_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, tx_busy, rx_data_avail} = 4'h0;
    {aresetn, tx_data, rx_bit, want, s_axi_wstrb} = {7'h00, 4'hF};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    tick(20);
    chk(32'({request_to_send_n, terminal_ready_n, multi_function_out_n,
      serial_tx, rx_sample, irq, tx_allowed}), 32'h7C);
    aresetn <= 1'b1;
    rd(`UMPC_MCR_OFF);
    chk(rdat, 32'h0);
    for (int s = 0; s < 4; s++) begin
      if (s == 1) wr(`UMPC_DIV_OFF, 32'h3);
      wr(`UMPC_AFR_OFF, 32'(s << 1));
      for (int k = 0; k < 6 && s != 1; k++) begin
        m = $random(seed) & 32'hB;
        wr(`UMPC_MCR_OFF, m);
        {rx_data_avail, tx_data, rx_bit} <= 3'($random(seed));
        tick(3);
        chk(32'({request_to_send_n, terminal_ready_n, multi_function_out_n}),
          32'({!m[1], !m[0], mf_exp(2'(s), m, rx_data_avail)}));
      end
      for (int k = 0; k < 2 && s == 1; k++) begin
        n = 0;
        b = multi_function_out_n;
        do begin @(posedge aclk); n++; end
        while (multi_function_out_n === b && n < 40);
        if (k == 1) chk(32'(n), 32'h3);
      end
    end
    wr(`UMPC_FEATURE_CONTROL_REG_OFF, 32'h8);
    for (int k = 0; k < 2; k++) begin
      tx_busy <= 1'(k);
      tick(3);
      chk(32'(request_to_send_n), 32'(k == 0));
    end
    wr(`UMPC_FEATURE_CONTROL_REG_OFF, 32'h0);
    wr(`UMPC_MCR_OFF, 32'h2);
    wr(`UMPC_EFR_OFF, 32'hC0);
    for (int k = 0; k < 2; k++) begin
      want <= 4'(k);
      tick(3);
      chk(32'(tx_allowed), 32'(k));
    end
    wr(`UMPC_EFR_OFF, 32'h0);
    want <= 4'hA;
    tick(3);
    rd(`UMPC_MSR_OFF);
    chk(rdat, 32'hA);
    rd(`UMPC_ISR_OFF);
    wr(`UMPC_IER_OFF, 32'h80);
    wr(`UMPC_IMASK_OFF, 32'h8);
    want <= 4'h2;
    tick(3);
    chk(32'(irq), 32'h1);
    rd(`UMPC_ISR_OFF);
    chk(rdat & 32'h8, 32'h8);
    tick(2);
    chk(32'(irq), 32'h0);
    wr(`UMPC_IMASK_OFF, 32'h0);
    want <= 4'hA;
    tick(3);
    chk(32'(irq), 32'h0);
    wr(12'h100, 32'h1);
    chk(32'(resp), 32'h2);
    rd(12'h100);
    chk({rdat[29:0], resp}, 32'h2);
    wr(`UMPC_MCR_OFF, 32'hB);
    {dev_reset, tx_data, rx_bit} <= 3'h4;
    tick(2);
    chk(32'({request_to_send_n, terminal_ready_n, multi_function_out_n,
      serial_tx, rx_sample, irq, tx_allowed}), 32'h7C);
    dev_reset <= 1'b0;
    rd(`UMPC_MCR_OFF);
    chk(rdat, 32'h0);
    stop_test();
  end
endmodule // tb_uart_modem_pin_and_mfout_control

// File: verification/umpc_modem_model.sv
`timescale 1ns/1ps
module umpc_modem_model (
  // Clock
  input  wire logic       aclk,
  // Wanted line states, 1 asserts the line
  input  wire logic [3:0] want,
  input  wire logic       rx_bit,
  // Modem side pins
  output logic            clear_to_send_n,
  output logic            set_ready_n,
  output logic            carrier_detect_n,
  output logic            ring_indicator_n,
  output logic            serial_rx
);
  // ---------------------------------------------------------------
  // Line drivers
  // ---------------------------------------------------------------
  // Idle high at start, as an unused input tied to supply
  initial begin
    {ring_indicator_n, carrier_detect_n} = 2'h3;
    {set_ready_n, clear_to_send_n, serial_rx} = 3'h7;
  end
  // Asserted is low; lines move only just after an edge
  always @(posedge aclk) begin
    {ring_indicator_n, carrier_detect_n} <= ~want[3:2];
    {set_ready_n, clear_to_send_n} <= ~want[1:0];
    serial_rx <= rx_bit;
  end
endmodule // umpc_modem_model

// File: verification/umpc_top_sva.sv
`timescale 1ns/1ps
module umpc_top_sva (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dev_reset,
  // Watched signals
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic request_to_send_n,
  input wire logic terminal_ready_n,
  input wire logic multi_function_out_n,
  input wire logic clear_to_send_n,
  input wire logic tx_data,
  input wire logic tx_busy,
  input wire logic serial_rx,
  input wire logic serial_tx,
  input wire logic rx_sample,
  input wire logic tx_allowed,
  input wire logic irq
);
  logic [2:0] wage_r;
  // Age of last write beat; saturates so old writes never wrap back
  always_ff @(posedge aclk) begin
    if (!aresetn) wage_r <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wage_r <= 3'h0;
    else if (wage_r != 3'h7) wage_r <= wage_r + 3'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_pins: assert property (
    dev_reset |=> request_to_send_n && terminal_ready_n
      && multi_function_out_n) else $error("pins not idle in reset");
  a_reset_quiet: assert property (
    dev_reset |=> !irq && !tx_allowed && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared in reset");
  a_reset_lines: assert property (
    dev_reset |=> serial_tx && rx_sample) else $error("line not idle");
  a_line_follow: assert property (
    !dev_reset |=> serial_tx == $past(tx_data)
      && rx_sample == $past(serial_rx)) else $error("line not passed");
  a_cts_gate: assert property (
    !dev_reset && !clear_to_send_n |=> tx_allowed)
    else $error("send not allowed with cts");
  a_dtr_cause: assert property (
    $changed(terminal_ready_n) |-> $past(dev_reset) || wage_r < 3'h5)
    else $error("dtr moved without write");
  a_rts_cause: assert property (
    $changed(request_to_send_n) |-> $past(dev_reset) || wage_r < 3'h5
      || $past(tx_busy) != $past(tx_busy, 2)) else $error("rts moved");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  cover property (dev_reset ##1 !dev_reset);
  cover property ($fell(request_to_send_n));
  cover property ($rose(irq));
endmodule // umpc_top_sva
bind umpc_top umpc_top_sva u_sva (.*);

// File: verilog/umpc_defs.svh
// Notes on behaviour
// - Request-to-send pin active low, software-driven output
// - Direction bit makes request-to-send drive transceiver
// - Clear-to-send active low: flow gate, interrupt
// - Terminal-ready pin active low, general output
// - Status inputs active low, readable as inputs
// - Two function bits select multi-function pin role
// - General role: pin low when control bit3 set
// - Control bit3 resets to zero, pin high
// - Baud role outputs sixteen-times sampling clock
// - Receive role: active-low receive-ready indicator
// - Active-high reset restores all registers, outputs
// - Reset holds transmit high, ignores receive
`ifndef UMPC_DEFS_SVH
`define UMPC_DEFS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UMPC_MCR_OFF    12'h000
`define UMPC_AFR_OFF    12'h004
`define UMPC_EFR_OFF    12'h008
`define UMPC_FEATURE_CONTROL_REG_OFF   12'h00C
`define UMPC_IER_OFF    12'h010
`define UMPC_MSR_OFF    12'h014
`define UMPC_ISR_OFF    12'h018
`define UMPC_IMASK_OFF  12'h01C
`define UMPC_DIV_OFF    12'h020
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define UMPC_MCR_DTR    0
`define UMPC_MCR_RTS    1
`define UMPC_MCR_OP2    3
`define UMPC_AFR_SEL_LO 1
`define UMPC_EFR_ARTS   6
`define UMPC_EFR_ACTS   7
`define UMPC_FEATURE_CONTROL_REG_DIR   3
`define UMPC_IER_CTS    7
// Status bits: 0 cts, 1 dsr, 2 cd, 3 ri change; 4 rx ready
`define UMPC_NEV        5
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define UMPC_DIV_RST    16'h0001
`define UMPC_RST_MIN_NS 40
`define UMPC_CLK_NS     40
`define UMPC_RST_CYC    ((`UMPC_RST_MIN_NS+`UMPC_CLK_NS-1)/`UMPC_CLK_NS)
`endif

// File: verilog/umpc_pkg.sv
package umpc_pkg;
  // Multi-function pin role
  typedef enum logic [1:0] {
    UMPC_MF_GPO,
    UMPC_MF_BAUD,
    UMPC_MF_RXRDY
  } umpc_mf_t;
  // Write channel states
  typedef enum logic [1:0] {
    UMPC_W_IDLE,
    UMPC_W_RESP
  } umpc_wst_t;
endpackage

// File: verilog/umpc_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "umpc_defs.svh"
module umpc_top #(
  parameter int DIVW = 16
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        dev_reset,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Modem pins
  output logic             request_to_send_n,
  input  wire logic        clear_to_send_n,
  output logic             terminal_ready_n,
  input  wire logic        set_ready_n,
  input  wire logic        carrier_detect_n,
  input  wire logic        ring_indicator_n,
  output logic             multi_function_out_n,
  // Serial data and core hooks
  output logic             serial_tx,
  input  wire logic        serial_rx,
  input  wire logic        tx_data,
  input  wire logic        tx_busy,
  input  wire logic        rx_data_avail,
  output logic             rx_sample,
  output logic             tx_allowed,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Reset combination
  // ---------------------------------------------------------------
  // Either reset clears everything; dev_reset is active high
  logic rst;
  assign rst = !aresetn || dev_reset;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]      mcr_r, afr_r, efr_r, feature_control_reg_r, ier_r;
  logic [`UMPC_NEV-1:0] isr_r, imask_r;
  logic [DIVW-1:0] div_r, cnt_r;
  logic [3:0]      st_r;
  logic            rxa_r, baud_r, aw_hold_r, w_hold_r, wstrb0_r;
  logic [11:0]     awaddr_r;
  logic [31:0]     wdata_r;
  logic            wr_go, rd_isr;
  logic [`UMPC_NEV-1:0] ev;
  umpc_pkg::umpc_mf_t mf_sel;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  // Address and data latched independently; answer after both
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        // Strobe is only valid with its data beat, so keep it too
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r > `UMPC_DIV_OFF) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
    end
  end

  // Software registers; wstrb lane 0 alone gates every one, div_r too
  always_ff @(posedge aclk) begin
    if (rst) begin
      mcr_r   <= 8'h00;
      afr_r   <= 8'h00;
      efr_r   <= 8'h00;
      feature_control_reg_r  <= 8'h00;
      ier_r   <= 8'h00;
      imask_r <= '0;
      div_r   <= DIVW'(`UMPC_DIV_RST);
    end else if (wr_go && wstrb0_r) begin
      unique case (awaddr_r)
        `UMPC_MCR_OFF:   mcr_r   <= wdata_r[7:0];
        `UMPC_AFR_OFF:   afr_r   <= wdata_r[7:0];
        `UMPC_EFR_OFF:   efr_r   <= wdata_r[7:0];
        `UMPC_FEATURE_CONTROL_REG_OFF:  feature_control_reg_r  <= wdata_r[7:0];
        `UMPC_IER_OFF:   ier_r   <= wdata_r[7:0];
        `UMPC_IMASK_OFF: imask_r <= wdata_r[`UMPC_NEV-1:0];
        `UMPC_DIV_OFF:   div_r   <= wdata_r[DIVW-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Modem status and events
  // ---------------------------------------------------------------
  // Pins are active low; stored inverted so 1 means asserted
  always_ff @(posedge aclk) begin
    if (rst) begin
      st_r  <= 4'h0;
      rxa_r <= 1'b0;
    end else begin
      st_r  <= {!ring_indicator_n, !carrier_detect_n,
                !set_ready_n, !clear_to_send_n};
      rxa_r <= rx_data_avail;
    end
  end

  // Change events; clear-to-send event needs its enable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ev
      if (gi == 0) begin : g_cts
        assign ev[gi] = ier_r[`UMPC_IER_CTS] &&
                        (st_r[gi] != !clear_to_send_n);
      end else begin : g_oth
        logic pin;
        assign pin = (gi == 1) ? !set_ready_n :
                     (gi == 2) ? !carrier_detect_n : !ring_indicator_n;
        assign ev[gi] = st_r[gi] != pin;
      end
    end
  endgenerate
  assign ev[4] = rx_data_avail && !rxa_r;

  // Sticky status; a new event beats the read-clear
  assign rd_isr = s_axi_arvalid && s_axi_arready &&
                  (s_axi_araddr == `UMPC_ISR_OFF);
  always_ff @(posedge aclk) begin
    if (rst) begin
      isr_r <= '0;
      irq   <= 1'b0;
    end else begin
      isr_r <= (rd_isr ? '0 : isr_r) | ev;
      irq   <= |(((rd_isr ? '0 : isr_r) | ev) & imask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          `UMPC_MCR_OFF:   s_axi_rdata <= {24'h000000, mcr_r};
          `UMPC_AFR_OFF:   s_axi_rdata <= {24'h000000, afr_r};
          `UMPC_EFR_OFF:   s_axi_rdata <= {24'h000000, efr_r};
          `UMPC_FEATURE_CONTROL_REG_OFF:  s_axi_rdata <= {24'h000000, feature_control_reg_r};
          `UMPC_IER_OFF:   s_axi_rdata <= {24'h000000, ier_r};
          `UMPC_MSR_OFF:   s_axi_rdata <= {28'h0000000, st_r};
          `UMPC_ISR_OFF:   s_axi_rdata <= {27'h0000000, isr_r};
          `UMPC_IMASK_OFF: s_axi_rdata <= {27'h0000000, imask_r};
          `UMPC_DIV_OFF:   s_axi_rdata <= {{(32-DIVW){1'b0}}, div_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sixteen-times baud clock
  // ---------------------------------------------------------------
  // Toggles every div_r cycles; a divisor of 0 is treated as 1
  always_ff @(posedge aclk) begin
    if (rst) begin
      cnt_r  <= '0;
      baud_r <= 1'b0;
    end else if (cnt_r + DIVW'(1) >= div_r) begin
      cnt_r  <= '0;
      baud_r <= !baud_r;
    end else begin
      cnt_r  <= cnt_r + DIVW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Reserved code 2'b11 falls back to the general role
  always_comb begin
    unique case (afr_r[`UMPC_AFR_SEL_LO +: 2])
      2'b01:   mf_sel = umpc_pkg::UMPC_MF_BAUD;
      2'b10:   mf_sel = umpc_pkg::UMPC_MF_RXRDY;
      default: mf_sel = umpc_pkg::UMPC_MF_GPO;
    endcase
  end

  // All pins registered; reset drives the idle high levels, tx_allowed low
  always_ff @(posedge aclk) begin
    if (rst) begin
      request_to_send_n    <= 1'b1;
      terminal_ready_n     <= 1'b1;
      multi_function_out_n <= 1'b1;
      serial_tx            <= 1'b1;
      rx_sample            <= 1'b1;
      tx_allowed           <= 1'b0;
    end else begin
      // Direction mode: low while transmitting, high to receive
      if (feature_control_reg_r[`UMPC_FEATURE_CONTROL_REG_DIR])
        request_to_send_n <= !tx_busy;
      else
        request_to_send_n <= !mcr_r[`UMPC_MCR_RTS];
      terminal_ready_n <= !mcr_r[`UMPC_MCR_DTR];
      unique case (mf_sel)
        umpc_pkg::UMPC_MF_BAUD:  multi_function_out_n <= baud_r;
        umpc_pkg::UMPC_MF_RXRDY:
          multi_function_out_n <= !rx_data_avail;
        umpc_pkg::UMPC_MF_GPO:
          multi_function_out_n <= !mcr_r[`UMPC_MCR_OP2];
      endcase
      serial_tx  <= tx_data;
      rx_sample  <= serial_rx;
      // Auto flow gate; relies on host asserting request first
      tx_allowed <= !efr_r[`UMPC_EFR_ACTS] || !clear_to_send_n;
    end
  end

endmodule // umpc_top
